// >>> counter_array_module_mode.v
// What this block does
// [RULE1] While the watchdog bit is set, a write to the global mode register only clears that bit, and only if its bit 6 is 0.
// [RULE2] With PWM on, mode bit 7 picks 8-bit (0) or 16-bit (1) resolution.
// [RULE3] Mode bit 6 enables the module comparator; clear disables it.
// [RULE4] Six 8-bit read/write module mode registers, modules 0 to 5, reset to zero.
// [RULE5] Mode bit 5 captures on rising pin edge, bit 4 on falling edge.
// [RULE6] With match enabled, counter equal to compare value sets the module flag.
// [RULE7] Toggle and PWM both set make the module a frequency output.
// [RULE8] PWM enabled drives a PWM waveform, 8-bit when the wide select is clear.
// [RULE9] Idle-control bit set halts the counter array while the processor idles.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "ccm_defines.vh"

module counter_array_module_mode #(
	parameter NCH = 6,
	parameter CW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire cpu_idle,
	input wire [NCH-1:0] module_io_pin_in,
	output wire [NCH-1:0] module_io_pin_out,
	output reg [NCH-1:0] module_io_pin_oe,
	output reg irq
);

// Maps a module number to its mode register index.
function [9:0] mode_idx;
	input integer n;
	begin
		case (n)
			0: mode_idx = `IDX_MODE0;
			1: mode_idx = `IDX_MODE1;
			2: mode_idx = `IDX_MODE2;
			3: mode_idx = `IDX_MODE3;
			4: mode_idx = `IDX_MODE4;
			default: mode_idx = `IDX_MODE5;
		endcase
	end
endfunction

wire [9:0] idx;
wire setup;
wire wr_go;
wire run;
wire ovf;
reg [7:0] gmode_q;
reg [7:0] gmode_d;
reg [CW-1:0] count_q;
reg [7:0] stat_q;
reg [7:0] mask_q;
reg [7:0] stat_set;
reg [31:0] rdata_d;
reg hit_d;
reg [8*NCH-1:0] mode_q;
reg [CW*NCH-1:0] cc_q;
reg [NCH-1:0] sync1_q;
reg [NCH-1:0] sync2_q;
wire [CW*NCH-1:0] cap_val;
wire [NCH-1:0] cap_stb;
wire [NCH-1:0] evt;

assign idx = paddr[11:2];
assign setup = psel & ~penable;
// A write lands on the first access edge, where pready is already high.
assign wr_go = psel & penable & pready & pwrite;
// Counter array stops while idle if the idle-control bit asks for it.
assign run = ~(gmode_q[`GB_IDLE] & cpu_idle); // [RULE9]
assign ovf = run & (count_q == `COUNT_MAX);

// Pin inputs pass two flip-flops before the channels look at them.
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		sync1_q <= {NCH{1'b0}};
		sync2_q <= {NCH{1'b0}};
	end
	else
	begin
		sync1_q <= module_io_pin_in;
		sync2_q <= sync1_q;
	end
end

// Free-running array counter, frozen while halted in idle.
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		count_q <= {CW{1'b0}};
	else if (run)
		count_q <= count_q + 1'b1; // [RULE9]
end

// Per-module mode and compare/capture registers plus channel logic.
genvar g;
generate
	for (g = 0; g < NCH; g = g + 1)
	begin : gen_ch
		always @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				mode_q[8*g +: 8] <= `MODE_RST; // [RULE4]
				cc_q[CW*g +: CW] <= `CC_RST;
				module_io_pin_oe[g] <= 1'b0;
			end
			else
			begin
				if (wr_go && idx == mode_idx(g))
					mode_q[8*g +: 8] <= pwdata[7:0]; // [RULE4]
				if (cap_stb[g])
					cc_q[CW*g +: CW] <= cap_val[CW*g +: CW];
				else if (wr_go && idx == `IDX_CC0 + g)
					cc_q[CW*g +: CW] <= pwdata[CW-1:0];
				module_io_pin_oe[g] <= mode_q[8*g+`MB_CMP] &
					(mode_q[8*g+`MB_PWM] | mode_q[8*g+`MB_TOG]);
			end
		end

		ccm_channel #(
			.W(CW)
		) u_ch (
			.clk(pclk),
			.rstn(presetn),
			.mode(mode_q[8*g +: 8]),
			.count(count_q),
			.cmp(cc_q[CW*g +: CW]),
			.pin_s(sync2_q[g]),
			.run(run),
			.cap_val_q(cap_val[CW*g +: CW]),
			.cap_stb_q(cap_stb[g]),
			.evt_q(evt[g]),
			.out_q(module_io_pin_out[g])
		);
	end
endgenerate

// Global mode next value; while the watchdog bit is set a write can only clear that bit.
always @*
begin
	gmode_d = gmode_q;
	if (wr_go && idx == `IDX_GMODE)
	begin
		if (!gmode_q[`GB_WDT])
			gmode_d = pwdata[7:0] & `GMODE_WMASK;
		else if (!pwdata[`GB_WDT])
			gmode_d[`GB_WDT] = 1'b0; // [RULE1]
	end
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		gmode_q <= `GMODE_RST;
	else
		gmode_q <= gmode_d; // [RULE1]
end

// Events that set sticky status bits.
always @*
begin
	stat_set = 8'h00;
	stat_set[NCH-1:0] = evt; // [RULE6]
	stat_set[`STAT_OVF] = ovf;
end

// Status is write-one-to-clear; a new event in the same cycle wins.
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		stat_q <= `STAT_RST;
		mask_q <= `MASK_RST;
		irq <= 1'b0;
	end
	else
	begin
		if (wr_go && idx == `IDX_STAT)
			stat_q <= (stat_q & ~pwdata[7:0]) | stat_set;
		else
			stat_q <= stat_q | stat_set; // [RULE6]
		if (wr_go && idx == `IDX_MASK)
			mask_q <= pwdata[7:0];
		irq <= |(stat_q & mask_q);
	end
end

// Read data and address decode, evaluated in the setup cycle.
always @*
begin : rd_mux
	integer i;
	rdata_d = 32'h0000_0000;
	hit_d = 1'b0;
	for (i = 0; i < NCH; i = i + 1)
	begin
		if (idx == mode_idx(i))
		begin
			rdata_d[7:0] = mode_q[8*i +: 8];
			hit_d = 1'b1;
		end
		if (idx == `IDX_CC0 + i)
		begin
			rdata_d[CW-1:0] = cc_q[CW*i +: CW];
			hit_d = 1'b1;
		end
	end
	case (idx)
		`IDX_GMODE:
		begin
			rdata_d[7:0] = gmode_q;
			hit_d = 1'b1;
		end
		`IDX_COUNT:
		begin
			rdata_d[CW-1:0] = count_q;
			hit_d = 1'b1;
		end
		`IDX_STAT:
		begin
			rdata_d[7:0] = stat_q;
			hit_d = 1'b1;
		end
		`IDX_MASK:
		begin
			rdata_d[7:0] = mask_q;
			hit_d = 1'b1;
		end
		default:
		begin
			rdata_d = rdata_d;
		end
	endcase
end

// APB answer: ready in the first access cycle, no wait states.
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end
	else if (setup)
	begin
		pready <= 1'b1;
		pslverr <= ~hit_d;
		prdata <= pwrite ? 32'h0000_0000 : rdata_d;
	end
	else
	begin
		pready <= 1'b0;
		pslverr <= 1'b0;
	end
end

endmodule // counter_array_module_mode

// >>> ccm_defines.vh
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_GMODE 10'h0D9
`define IDX_MODE0 10'h0DA
`define IDX_MODE1 10'h0DB
`define IDX_MODE2 10'h0DC
`define IDX_MODE3 10'h0DD
`define IDX_MODE4 10'h0DE
`define IDX_MODE5 10'h0CE
`define IDX_CC0 10'h040
`define IDX_COUNT 10'h048
`define IDX_STAT 10'h050
`define IDX_MASK 10'h051

// Module mode register fields.
`define MB_WIDE 7
`define MB_CMP 6
`define MB_RISE 5
`define MB_FALL 4
`define MB_MATCH 3
`define MB_TOG 2
`define MB_PWM 1
`define MB_ECCF 0

// Global mode register fields and writable bits.
`define GB_IDLE 7
`define GB_WDT 6
`define GB_OVF 0
`define GMODE_WMASK 8'hC1

// Status bit of the counter overflow event.
`define STAT_OVF 7

// Reset values and the counter top value.
`define MODE_RST 8'h00
`define GMODE_RST 8'h00
`define CC_RST 16'h0000
`define STAT_RST 8'h00
`define MASK_RST 8'h00
`define COUNT_MAX 16'hFFFF

`endif

// >>> ccm_channel.v
`timescale 1ns/1ps
`include "ccm_defines.vh"

module ccm_channel #(
	parameter W = 16
) (
	input wire clk,
	input wire rstn,
	input wire [7:0] mode,
	input wire [W-1:0] count,
	input wire [W-1:0] cmp,
	input wire pin_s,
	input wire run,
	output reg [W-1:0] cap_val_q,
	output reg cap_stb_q,
	output reg evt_q,
	output reg out_q
);

reg pin_prev_q;
wire rise;
wire fall;
wire cap_hit;
wire match_full;
wire match_low;
wire cmp_on;
reg out_d;

// Edge detection on the synchronised pin and comparator matches.
assign rise = pin_s & ~pin_prev_q;
assign fall = ~pin_s & pin_prev_q;
assign cap_hit = (rise & mode[`MB_RISE]) | (fall & mode[`MB_FALL]); // [RULE5]
assign match_full = run & (count == cmp);
assign match_low = run & (count[7:0] == cmp[7:0]);
assign cmp_on = mode[`MB_CMP]; // [RULE3]

// Output pin: frequency output, PWM, toggle, else hold.
always @*
begin
	out_d = out_q;
	if (cmp_on & mode[`MB_PWM] & mode[`MB_TOG])
	begin
		if (match_low)
			out_d = ~out_q; // [RULE7]
	end
	else if (cmp_on & mode[`MB_PWM])
	begin
		if (mode[`MB_WIDE])
			out_d = (count < cmp); // [RULE2]
		else
			out_d = (count[7:0] < cmp[W-1:W-8]); // [RULE8]
	end
	else if (cmp_on & mode[`MB_TOG] & match_full)
		out_d = ~out_q;
end

// Capture, event pulse and pin state registers.
always @(posedge clk or negedge rstn)
begin
	if (!rstn)
	begin
		pin_prev_q <= 1'b0;
		cap_val_q <= {W{1'b0}};
		cap_stb_q <= 1'b0;
		evt_q <= 1'b0;
		out_q <= 1'b0;
	end
	else
	begin
		pin_prev_q <= pin_s;
		cap_stb_q <= cap_hit;
		if (cap_hit)
			cap_val_q <= count; // [RULE5]
		evt_q <= cap_hit | (cmp_on & mode[`MB_MATCH] & match_full); // [RULE6]
		out_q <= out_d;
	end
end

endmodule // ccm_channel

// >>> counter_array_module_mode_checker.sv
`timescale 1ns/1ps
module counter_array_module_mode_checker #(
	parameter NCH = 6,
	parameter CW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire cpu_idle,
	input wire [NCH-1:0] module_io_pin_in,
	input wire [NCH-1:0] module_io_pin_out,
	input wire [NCH-1:0] module_io_pin_oe,
	input wire irq
);
	reg [7:0] g_q;
	wire [9:0] ix = paddr[11:2];
	wire md = ix == 10'h0CE || (ix >= 10'h0DA && ix <= 10'h0DE);
	wire gw = psel && penable && pready && pwrite && ix == 10'h0D9;
	// Shadow of the global mode register; a set lock only lets bit 6 clear.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			g_q <= 8'h00;
		else if (gw)
			g_q <= g_q[6] ? (g_q & {1'h1, pwdata[6], 6'h3F})
				: (pwdata[7:0] & 8'hC1);
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd;
		psel && penable && pready && !pwrite;
	endsequence
	AST_RDY: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	AST_ONE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_SLV: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_MAP: assert property (pready && md |-> !pslverr)
		else $error("mode register refused");
	AST_HI: assert property (s_rd ##0 md |-> prdata[31:8] == 24'h0)
		else $error("mode read upper bits set");
	AST_GLB: assert property (s_rd ##0 ix == 10'h0D9 |-> prdata[7:0] == g_q)
		else $error("global mode value wrong");
	AST_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved");
	AST_OUT: assert property (((module_io_pin_out ^ $past(module_io_pin_out))
		& ~(module_io_pin_oe | $past(module_io_pin_oe))) == 6'h0)
		else $error("pin moved while not driven");
endmodule // counter_array_module_mode_checker
bind counter_array_module_mode counter_array_module_mode_checker
	#(.NCH(NCH), .CW(CW)) i_chk (.*);

// >>> tb_counter_array_module_mode.sv
`timescale 1ns/1ps
module tb_counter_array_module_mode;
	reg pclk = 1'h0;
	reg presetn = 1'h0;
	reg psel = 1'h0;
	reg penable = 1'h0;
	reg pwrite = 1'h0;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0;
	reg cpu_idle = 1'h0;
	reg [5:0] pin = 6'h0;
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	wire [5:0] pout, poe;
	integer error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h391A;
	integer hi, tg, i, p;
	reg [32:0] exp_q [$];
	reg [9:0] mi [0:5] = '{10'h0DA, 10'h0DB, 10'h0DC, 10'h0DD, 10'h0DE, 10'h0CE};
	reg [31:0] d;
	always #25 pclk = ~pclk;
	counter_array_module_mode i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_idle(cpu_idle), .module_io_pin_in(pin),
		.module_io_pin_out(pout), .module_io_pin_oe(poe), .irq(irq));
	task chk(input string nm, input [63:0] s, input [63:0] e);
	begin
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %0h seen %0h", nm, e, s);
		end
	end
	endtask
	task results;
	begin
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// One APB transfer; a read leaves its expected answer in the queue.
	task apb(input w, input [9:0] a, input [31:0] dd, input [32:0] e);
	begin
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {a, 2'h0};
		pwdata <= dd;
		if (!w)
			exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
	end
	endtask
	// Sets module 0 up, then counts high cycles and edges of its pin.
	task meas(input [7:0] m, input [15:0] c, input ih, input [8:0] eh,
		input [8:0] et);
	begin
		cpu_idle <= ih;
		apb(1, 10'h040, {16'h0, c}, 0);
		apb(1, 10'h0DA, {24'h0, m}, 0);
		repeat (8) @(posedge pclk);
		hi = 0;
		tg = 0;
		p = pout[0];
		repeat (256)
		begin
			@(posedge pclk);
			hi += pout[0];
			tg += pout[0] ^ p;
			p = pout[0];
		end
		chk("oe", poe[0], m[6]);
		chk("edges", tg, et);
		if (eh != 9'h1FF)
			chk("high", hi, eh);
	end
	endtask
	// Compares each read answer with the oldest note.
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'h1 && !pwrite)
			chk("read", {pslverr, prdata}, exp_q.pop_front());
	end
	// Cuts a hang short.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			results;
		end
	end
	// Main sequence.
	initial
	begin
		pin = $random(seed) & 6'h38;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		for (i = 0; i < 6; i++)
		begin
			d = $random(seed);
			apb(0, mi[i], 0, 0);
			apb(1, mi[i], d, 0);
			apb(0, mi[i], 0, {25'h0, d[7:0]});
			apb(1, mi[i], 0, 0);
		end
		apb(1, 10'h3FF, d, 0);
		apb(0, 10'h3FF, 0, {1'h1, 32'h0});
		$display("registers done");
		apb(1, 10'h0D9, 32'hFF, 0);
		apb(0, 10'h0D9, 0, 33'hC1);
		apb(1, 10'h0D9, 32'h40, 0);
		apb(0, 10'h0D9, 0, 33'hC1);
		apb(1, 10'h0D9, 32'h0, 0);
		apb(0, 10'h0D9, 0, 33'h81);
		apb(1, 10'h0D9, 32'h80, 0);
		apb(0, 10'h0D9, 0, 33'h80);
		$display("lock done");
		meas(8'h02, 16'h8000, 0, 0, 0);
		meas(8'h42, 16'h8000, 0, 128, 2);
		meas(8'hC2, 16'hFF00, 0, 256, 0);
		meas(8'h46, 16'h0010, 0, 9'h1FF, 1);
		meas(8'h46, 16'h0010, 1, 9'h1FF, 0);
		cpu_idle <= 1'h0;
		$display("pin modes done");
		// A second reset restarts the counter so a 16-bit match comes soon.
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1, 10'h040, 32'h40, 0);
		apb(1, 10'h051, 1, 0);
		apb(1, 10'h050, 32'hFF, 0);
		apb(1, 10'h0DA, 32'h48, 0);
		i = 0;
		while (irq !== 1'h1 && i < 300)
		begin
			@(posedge pclk);
			i++;
		end
		chk("irq", irq, 1);
		apb(1, 10'h0DA, 0, 0);
		apb(0, 10'h050, 0, 33'h01);
		apb(1, 10'h051, 0, 0);
		repeat (2) @(posedge pclk);
		chk("irq", irq, 0);
		apb(1, 10'h050, 1, 0);
		apb(0, 10'h050, 0, 0);
		$display("match done");
		pin[2] <= 1'h1;
		apb(1, 10'h0DB, 32'h20, 0);
		apb(1, 10'h0DC, 32'h10, 0);
		pin[1] <= 1'h1;
		pin[2] <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(0, 10'h050, 0, 33'h06);
		$display("capture done");
		results;
	end
endmodule // tb_counter_array_module_mode
